// file: rtl/can_bit_timing_error_detect.sv
// CAN bit timing, sampling, error detection and the bit descriptor FIFO.
`timescale 1ns/100ps
`default_nettype none

// Flip-flop FIFO with valid and ready on both sides and a flush.
module can_bit_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Depth must be a power of two so the pointers wrap by themselves.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("FIFO depth must be a power of two of at least 2.");
    end

    // Handshake terms come straight from the fill count.
    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Storage writes.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count; a flush drops every entry.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // can_bit_fifo

// Bit timing and error detection for one CAN node.
module can_bit_timing_error_detect #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic config_mode,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [7:0] cfg_data,
    output logic [7:0] bit_timing_control_1,
    output logic [7:0] bit_timing_control_2,
    output logic [7:0] bit_timing_control_3,
    input wire logic desc_valid,
    output logic desc_ready,
    input wire can_pkg::bit_desc_s desc_data,
    input wire logic can_receive_pin,
    output logic can_transmit_pin,
    output logic bit_start,
    output logic sample_point,
    output logic rx_bit_valid,
    output logic rx_bit,
    output can_pkg::frame_field_e rx_field,
    output logic [14:0] crc_value,
    output can_pkg::err_flags_s err_status,
    input wire can_pkg::err_flags_s err_clear,
    output logic error_frame_active,
    output logic repeat_req
);
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    logic [7:0] c3_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic rx_lvl_q;
    logic rx_prev_q;
    logic [5:0] pre_q;
    logic tick;
    logic [6:0] hq_q;
    logic [3:0] ext_q;
    logic [3:0] shrink_q;
    logic synced_q;
    logic [3:0] sjw_tq;
    logic [3:0] prop_tq;
    logic [3:0] ph1_tq;
    logic [3:0] ph2_tq;
    logic [6:0] sp_tq;
    logic [6:0] sp_hq;
    logic [6:0] end_hq;
    logic [6:0] rem_hq;
    logic fall;
    logic short_now;
    logic wrap;
    logic smp_a_q;
    logic smp_b_q;
    logic bit_val;
    can_pkg::bit_desc_s cur_q;
    can_pkg::bit_desc_s fifo_out;
    logic fifo_valid;
    logic stuff_slot_q;
    logic stuff_need;
    logic last_q;
    logic [2:0] run_q;
    logic [14:0] crc_q;
    logic [14:0] crc_rx_q;
    logic [14:0] crc_base;
    logic crc_fb;
    logic in_stuff;
    logic in_crc;
    can_pkg::err_flags_s err_now;
    logic err_pend_q;
    logic err_act_q;
    logic [4:0] err_cnt_q;
    logic active_smp;

    // Timing registers, frozen outside configuration mode.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            c1_q <= can_pkg::CTRL_RESET;
            c2_q <= can_pkg::CTRL_RESET;
            c3_q <= can_pkg::CTRL_RESET;
        end else if (cfg_wr && config_mode) begin
            if (cfg_sel == can_pkg::SEL_CTRL1) begin
                c1_q <= cfg_data;
            end else if (cfg_sel == can_pkg::SEL_CTRL2) begin
                c2_q <= cfg_data;
            end else if (cfg_sel == can_pkg::SEL_CTRL3) begin
                c3_q <= cfg_data;
            end
        end
    end
    assign bit_timing_control_1 = c1_q;
    assign bit_timing_control_2 = c2_q;
    assign bit_timing_control_3 = c3_q;

    // Segment lengths in quanta; each field holds length minus one.
    always_comb begin
        sjw_tq = {2'h0, c1_q[can_pkg::SJW_LSB +: 2]} + 4'h1;
        prop_tq = {1'b0, c2_q[can_pkg::PROPAGATION_SEGMENT_LENGTH_LSB +: 3]} + 4'h1;
        ph1_tq = {1'b0, c2_q[can_pkg::PH1_LSB +: 3]} + 4'h1;
        if (c2_q[can_pkg::PHTS_BIT]) begin
            ph2_tq = {1'b0, c3_q[can_pkg::PH2_LSB +: 3]} + 4'h1;
        end else if (ph1_tq > can_pkg::IPT_TQ) begin
            ph2_tq = ph1_tq;
        end else begin
            ph2_tq = can_pkg::IPT_TQ;
        end
    end

    // Bit layout in half quanta: sync, propagation, phase one, phase two.
    assign sp_tq = can_pkg::SYNC_TQ + {3'h0, prop_tq} + {3'h0, ph1_tq}
        + {3'h0, ext_q};
    assign sp_hq = {sp_tq[5:0], 1'b0};
    assign end_hq = sp_hq + {2'h0, ph2_tq - shrink_q, 1'b0};
    assign rem_hq = end_hq - hq_q;

    // Receive pin passes three flops; a change counts when two agree.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            s1_q <= can_receive_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                rx_lvl_q <= s3_q;
            end
        end
    end

    // Prescaler makes one half-quantum tick every prescaler+1 clocks.
    assign tick = (pre_q == c1_q[can_pkg::BRP_LSB +: can_pkg::BRP_W]);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // Falling edges at tick rate, own dominant excluded.
    assign fall = tick && rx_prev_q && !rx_lvl_q && can_transmit_pin;
    assign short_now = fall && !synced_q && (hq_q >= sp_hq)
        && (rem_hq[6:1] <= {2'h0, sjw_tq});
    assign wrap = tick && ((hq_q == end_hq - 7'h01) || short_now);
    assign bit_start = wrap;
    assign sample_point = tick && (hq_q == sp_hq - 7'h01);

    // Bit position counter with hard sync and jump-width resync.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hq_q <= '0;
            ext_q <= '0;
            shrink_q <= '0;
            synced_q <= 1'b0;
            rx_prev_q <= 1'b1;
        end else if (tick) begin
            rx_prev_q <= rx_lvl_q;
            if (fall && cur_q.field == can_pkg::FLD_IDLE && !err_act_q) begin
                hq_q <= 7'h02;
                ext_q <= '0;
                shrink_q <= '0;
                synced_q <= 1'b1;
            end else if (wrap) begin
                hq_q <= '0;
                ext_q <= '0;
                shrink_q <= '0;
                synced_q <= 1'b0;
            end else begin
                hq_q <= hq_q + 7'h01;
                if (fall && !synced_q && hq_q >= 7'h02) begin
                    synced_q <= 1'b1;
                    if (hq_q < sp_hq) begin
                        if (hq_q[6:1] < {2'h0, sjw_tq}) begin
                            ext_q <= hq_q[4:1];
                        end else begin
                            ext_q <= sjw_tq;
                        end
                    end else begin
                        shrink_q <= sjw_tq;
                    end
                end
            end
        end
    end

    // Early samples one quantum and half a quantum before.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            smp_a_q <= 1'b1;
            smp_b_q <= 1'b1;
        end else if (tick) begin
            if (hq_q == sp_hq - 7'h03) begin
                smp_a_q <= rx_lvl_q;
            end
            if (hq_q == sp_hq - 7'h02) begin
                smp_b_q <= rx_lvl_q;
            end
        end
    end

    // Received bit: majority of three, or the sample point level alone.
    always_comb begin
        if (c2_q[can_pkg::SAM_BIT]) begin
            bit_val = (smp_a_q & smp_b_q) | (smp_a_q & rx_lvl_q)
                | (smp_b_q & rx_lvl_q);
        end else begin
            bit_val = rx_lvl_q;
        end
    end

    // Field classes for stuffing and checksum coverage.
    assign in_stuff = (cur_q.field >= can_pkg::FLD_SOF)
        && (cur_q.field <= can_pkg::FLD_CRC);
    assign in_crc = (cur_q.field >= can_pkg::FLD_SOF)
        && (cur_q.field <= can_pkg::FLD_DATA);
    assign active_smp = sample_point && !err_act_q
        && cur_q.field != can_pkg::FLD_IDLE;
    assign stuff_need = in_stuff && run_q == can_pkg::STUFF_LIMIT;
    assign desc_ready = wrap && fifo_valid && !err_act_q && !err_pend_q && !stuff_need;

    can_bit_fifo #(
        .WIDTH($bits(can_pkg::bit_desc_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_desc_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .flush(wrap && err_pend_q && !err_act_q),
        .in_valid(desc_valid),
        .in_ready(),
        .in_data(desc_data),
        .out_valid(fifo_valid),
        .out_ready(desc_ready),
        .out_data(fifo_out)
    );

    // Error checks on each sampled bit.
    always_comb begin
        err_now = '0;
        if (active_smp) begin
            err_now.stuff = in_stuff && bit_val == last_q
                && run_q == can_pkg::STUFF_LIMIT;
            err_now.form = !bit_val
                && (cur_q.field == can_pkg::FLD_CRC_DELIM
                || cur_q.field == can_pkg::FLD_ACK_DELIM
                || cur_q.field == can_pkg::FLD_EOF
                || cur_q.field == can_pkg::FLD_IFS);
            err_now.ack = cur_q.own && cur_q.field == can_pkg::FLD_ACK
                && bit_val;
            err_now.bit_mismatch = cur_q.own && bit_val != cur_q.level
                && !(cur_q.level && (cur_q.field == can_pkg::FLD_ARB
                || cur_q.field == can_pkg::FLD_ACK));
            err_now.crc = !cur_q.own
                && cur_q.field == can_pkg::FLD_CRC_DELIM
                && crc_rx_q != crc_q;
        end
    end

    // Checksum shift over start through data, stuff bits left out.
    assign crc_base = (cur_q.field == can_pkg::FLD_SOF) ? '0 : crc_q;
    assign crc_fb = bit_val ^ crc_base[14];
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crc_q <= '0;
            crc_rx_q <= '0;
        end else if (active_smp && !stuff_slot_q) begin
            if (in_crc) begin
                crc_q <= {crc_base[13:0], 1'b0}
                    ^ (crc_fb ? can_pkg::CRC_POLY : '0);
            end
            if (cur_q.field == can_pkg::FLD_CRC) begin
                crc_rx_q <= {crc_rx_q[13:0], bit_val};
            end
        end
    end
    assign crc_value = crc_q;

    // Run length of equal bits inside the stuffed region.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            last_q <= 1'b1;
            run_q <= '0;
        end else if (err_act_q || (sample_point && cur_q.field == can_pkg::FLD_IDLE)) begin
            run_q <= '0;
        end else if (active_smp) begin
            last_q <= bit_val;
            if (!in_stuff || cur_q.field == can_pkg::FLD_SOF) begin
                run_q <= in_stuff ? 3'h1 : 3'h0;
            end else if (bit_val == last_q) begin
                if (run_q != can_pkg::STUFF_LIMIT) begin
                    run_q <= run_q + 3'h1;
                end
            end else begin
                run_q <= 3'h1;
            end
        end
    end

    // Sticky error status; a new error wins over a clear.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_status <= '0;
        end else begin
            err_status <= can_pkg::err_flags_s'((err_status & ~err_clear)
                | err_now);
        end
    end

    // Received bit output for the frame logic.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_bit_valid <= 1'b0;
            rx_bit <= 1'b1;
            rx_field <= can_pkg::FLD_IDLE;
        end else begin
            rx_bit_valid <= active_smp && !stuff_slot_q;
            if (active_smp && !stuff_slot_q) begin
                rx_bit <= bit_val;
                rx_field <= cur_q.field;
            end
        end
    end

    // Per bit: descriptor, stuff bit or error frame.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_q <= can_pkg::IDLE_DESC;
            stuff_slot_q <= 1'b0;
            err_pend_q <= 1'b0;
            err_act_q <= 1'b0;
            err_cnt_q <= '0;
            can_transmit_pin <= 1'b1;
            repeat_req <= 1'b0;
        end else begin
            repeat_req <= 1'b0;
            if (err_now != '0) begin
                err_pend_q <= 1'b1;
            end
            if (wrap) begin
                stuff_slot_q <= 1'b0;
                if (err_act_q) begin
                    err_cnt_q <= err_cnt_q + 5'h01;
                    can_transmit_pin <= (err_cnt_q + 5'h01)
                        >= can_pkg::ERR_FLAG_BITS;
                    if (err_cnt_q == can_pkg::ERR_TOTAL_BITS - 5'h01) begin
                        err_act_q <= 1'b0;
                        can_transmit_pin <= 1'b1;
                        repeat_req <= 1'b1;
                    end
                end else if (err_pend_q || err_now != '0) begin
                    err_pend_q <= 1'b0;
                    err_act_q <= 1'b1;
                    err_cnt_q <= '0;
                    cur_q <= can_pkg::IDLE_DESC;
                    can_transmit_pin <= 1'b0;
                end else if (stuff_need) begin
                    stuff_slot_q <= 1'b1;
                    can_transmit_pin <= cur_q.own ? !last_q : 1'b1;
                end else if (fifo_valid) begin
                    cur_q <= fifo_out;
                    can_transmit_pin <= fifo_out.level;
                end else begin
                    cur_q <= can_pkg::IDLE_DESC;
                    can_transmit_pin <= 1'b1;
                end
            end
        end
    end
    assign error_frame_active = err_act_q;
endmodule // can_bit_timing_error_detect

`default_nettype wire

// file: include/can_pkg.sv
// Constants, types and field layouts for the CAN bit timing and error block.
// Operation
// - Timing writes accepted only in configuration mode.
// - Prescaler sets quantum; jump width limits resync.
// - Propagation and phase-one lengths in quanta.
// - Sample point at end of phase one.
// - Triple mode: three samples, half-quantum apart.
// - Triple mode: majority of three is bit.
// - Single mode: one sample at sample point.
// - Phase-two source set: use phase-two field.
// - Source clear: phase two is max(phase1, 2).
// - Phase-two field ignored while source clear.
// - Transmitter computes CRC from start to data.
// - Receiver compares CRC; mismatch flags error, repeats.
// - Recessive acknowledge slot unanswered: acknowledge error.
// - Dominant in delimiters, end or gap: form error.
// - Transmitter flags readback differing from sent bit; in a stuff slot the code compares readback with the descriptor level instead.
// - No bit error for a sent recessive in arbitration or acknowledge.
// - Six equal bits in stuffed region: stuff error.
package can_pkg;
    localparam logic [1:0] SEL_CTRL1 = 2'h0;
    localparam logic [1:0] SEL_CTRL2 = 2'h1;
    localparam logic [1:0] SEL_CTRL3 = 2'h2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int BRP_LSB = 0;
    localparam int BRP_W = 6;
    localparam int SJW_LSB = 6;
    localparam int PROPAGATION_SEGMENT_LENGTH_LSB = 0;
    localparam int PH1_LSB = 3;
    localparam int SAM_BIT = 6;
    localparam int PHTS_BIT = 7;
    localparam int PH2_LSB = 0;
    localparam logic [6:0] SYNC_TQ = 7'h01;
    localparam logic [3:0] IPT_TQ = 4'h2;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [2:0] STUFF_LIMIT = 3'h5;
    localparam logic [4:0] ERR_FLAG_BITS = 5'h06;
    localparam logic [4:0] ERR_TOTAL_BITS = 5'h0E;
    typedef enum logic [3:0] {
        FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2,
        FLD_CTRL = 4'h3, FLD_DATA = 4'h4, FLD_CRC = 4'h5,
        FLD_CRC_DELIM = 4'h6, FLD_ACK = 4'h7,
        FLD_ACK_DELIM = 4'h8, FLD_EOF = 4'h9, FLD_IFS = 4'hA
    } frame_field_e;
    typedef struct packed {
        frame_field_e field;
        logic own;
        logic level;
    } bit_desc_s;
    localparam bit_desc_s IDLE_DESC = '{FLD_IDLE, 1'b0, 1'b1};
    typedef struct packed {
        logic crc;
        logic ack;
        logic form;
        logic bit_mismatch;
        logic stuff;
    } err_flags_s;
endpackage

// file: testbench/can_peer_node.sv
// Behavioural model of another node on the shared CAN bus.
`timescale 1ns/100ps
`default_nettype none
module can_peer_node #(
    parameter int DELAY = 1
) (
    input wire logic clk_sys,
    input wire logic dut_tx,
    input wire logic peer_level,
    output logic bus_level
);
    logic [DELAY:0] pipe_q = '1;
    // Wired-AND bus with DELAY+1 clocks of line delay.
    always_ff @(posedge clk_sys) begin
        pipe_q <= {pipe_q[DELAY-1:0], dut_tx & peer_level};
    end
    assign bus_level = pipe_q[DELAY];
endmodule // can_peer_node
`default_nettype wire

// file: testbench/can_bte_sva.sv
// Concurrent checks on the ports of the CAN bit timing and error block.
`timescale 1ns/100ps
`default_nettype none
module can_bte_sva (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic config_mode,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [7:0] cfg_data,
    input wire logic [7:0] bit_timing_control_1,
    input wire logic [7:0] bit_timing_control_2,
    input wire logic [7:0] bit_timing_control_3,
    input wire logic bit_start,
    input wire logic sample_point,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic can_transmit_pin,
    input wire can_pkg::err_flags_s err_status,
    input wire can_pkg::err_flags_s err_clear,
    input wire logic error_frame_active,
    input wire logic repeat_req
);
    default clocking dck @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    cfg_hold_a: assert property (!(cfg_wr && config_mode) |=>
        $stable(bit_timing_control_1) && $stable(bit_timing_control_2)
        && $stable(bit_timing_control_3)) else $error("reg changed");
    cfg_take_a: assert property (cfg_wr && config_mode && cfg_sel == can_pkg::SEL_CTRL2
        |=> bit_timing_control_2 == $past(cfg_data)) else $error("write not taken");
    start_pulse_a: assert property (bit_start |-> !sample_point ##1 !bit_start)
        else $error("bad bit start");
    rx_after_sp_a: assert property (rx_bit_valid |-> $past(sample_point))
        else $error("bit off sample");
    tx_edge_a: assert property (can_transmit_pin != $past(can_transmit_pin)
        |-> $past(bit_start)) else $error("tx off boundary");
    frame_start_a: assert property ($rose(error_frame_active)
        |-> $past(bit_start) || $past(bit_start, 2)) else $error("frame off boundary");
    flag_sticky_a: assert property (
        ($past(err_status) & ~err_status & ~$past(err_clear)) == 5'h00) else $error("flag dropped");
    flag_at_sp_a: assert property ((err_status & ~$past(err_status)) != 5'h00
        |-> $past(sample_point)) else $error("flag off sample");
    repeat_pulse_a: assert property (repeat_req
        |-> $past(error_frame_active) ##1 !repeat_req) else $error("bad repeat pulse");
    cover property ($rose(error_frame_active));
    cover property (repeat_req);
    cover property (rx_bit_valid && !rx_bit);
endmodule // can_bte_sva
bind can_bit_timing_error_detect can_bte_sva i_sva (.*);
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the CAN bit timing and error block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int FIFO_DEPTH = 16;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic config_mode = 1'b1;
    logic cfg_wr = 1'b0;
    logic [1:0] cfg_sel = 2'h0;
    logic [7:0] cfg_data = 8'h00;
    logic [7:0] c1, c2, c3, bit_timing_control_1, bit_timing_control_2, bit_timing_control_3;
    logic desc_valid = 1'b0;
    can_pkg::bit_desc_s desc_data = can_pkg::IDLE_DESC;
    can_pkg::err_flags_s err_clear = '0;
    can_pkg::err_flags_s err_status;
    can_pkg::frame_field_e rx_field;
    logic [14:0] crc_value;
    logic desc_ready, bus_level, can_transmit_pin, bit_start, sample_point, rx_bit_valid;
    logic rx_bit, error_frame_active, repeat_req;
    logic peer_level = 1'b1;
    logic [31:0] lfsr_q = 32'h00013544;
    int errors = 0;
    int checked = 0;
    int off, n;
    // Free-running system clock.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    can_bit_timing_error_detect #(.FIFO_DEPTH(FIFO_DEPTH)) i_dut (.can_receive_pin(bus_level), .*);
    can_peer_node #(.DELAY(1)) i_peer (.dut_tx(can_transmit_pin), .*);
    // Pseudo-random source with a fixed start value.
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    // Bit length, or sample point offset, in clocks.
    function automatic int bit_clk(logic [7:0] b1, logic [7:0] b2, logic [7:0] b3, bit sp);
        int tq, p1, p2;
        tq = 2 * (b1[5:0] + 1);
        p1 = b2[5:3] + 1;
        p2 = b2[7] ? b3[2:0] + 1 : (p1 > 2 ? p1 : 2);
        return sp ? tq * (2 + b2[2:0] + p1) : tq * (2 + b2[2:0] + p1 + p2);
    endfunction
    // Expected bit for the sampling window.
    function automatic logic maj_exp(int triple_sample_select, int wide);
        return triple_sample_select == 1 ? 1'(wide) : 1'b1;
    endfunction
    task automatic wrap_up();
        $display("counts: %0d checks, %0d mismatches", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Waits for the pulse of kind k.
    task automatic wait_on(int k);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk_sys);
            if ((k == 0 && bit_start === 1'b1) || (k == 1 && sample_point === 1'b1)
                || (k == 2 && rx_bit_valid === 1'b1) || (k == 3 && repeat_req === 1'b1)) begin
                return;
            end
        end
        errors++;
        $display("mismatch wait_%0d expected 1 seen 0", k);
        wrap_up();
    endtask
    task automatic cfg_write(logic [1:0] sel, logic [7:0] d, logic mode);
        @(negedge clk_sys);
        config_mode = mode;
        cfg_sel = sel;
        cfg_data = d;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        config_mode = 1'b1;
    endtask
    task automatic push(can_pkg::frame_field_e f, logic own, logic lvl, int cnt);
        repeat (cnt) begin
            @(negedge clk_sys);
            desc_valid = 1'b1;
            desc_data = '{f, own, lvl};
        end
        @(negedge clk_sys);
        desc_valid = 1'b0;
    endtask
    // Measures one bit and its sample point.
    task automatic measure(output int len, output int sp);
        len = 0;
        sp = 0;
        wait_on(0);
        while (len < 1000) begin
            @(negedge clk_sys);
            len++;
            if (sample_point === 1'b1) sp = len;
            if (bit_start === 1'b1) break;
        end
    endtask
    // Runs one error case.
    task automatic run_case(can_pkg::frame_field_e f, logic own, logic lvl, logic plv,
        int cnt, logic [4:0] exp);
        int dom;
        dom = 0;
        wait_on(0);
        push(f, own, lvl, cnt);
        repeat (cnt) begin
            wait_on(0);
            peer_level = plv;
        end
        wait_on(1);
        peer_level = 1'b1;
        @(negedge clk_sys);
        check("err_status", 16'(5'(err_status) & {f != can_pkg::FLD_CRC_DELIM, 4'hF}), 16'(exp));
        if (exp != 5'h00) begin
            for (int i = 0; i < 4000 && repeat_req !== 1'b1; i++) begin
                @(negedge clk_sys);
                if (sample_point === 1'b1 && error_frame_active === 1'b1
                    && can_transmit_pin === 1'b0) dom++;
            end
            if (repeat_req !== 1'b1) wait_on(3);
            check("flag_bits", 16'(dom), 16'(can_pkg::ERR_FLAG_BITS));
        end
        err_clear = '1;
        @(negedge clk_sys);
        err_clear = '0;
    endtask
    // Main sequence.
    initial begin
        can_pkg::frame_field_e form_f[4];
        form_f = '{can_pkg::FLD_CRC_DELIM, can_pkg::FLD_ACK_DELIM, can_pkg::FLD_EOF,
            can_pkg::FLD_IFS};
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        check("control_1", 16'(bit_timing_control_1), 16'(can_pkg::CTRL_RESET));
        check("err_status", 16'(err_status), 16'h0000);
        for (int s = 0; s < 3; s++) begin
            c1 = 8'(rnd());
            cfg_write(2'(s), c1, 1'b1);
            cfg_write(2'(s), ~c1, 1'b0);
            cfg_write(2'h3, ~c1, 1'b1);
            check("control", 16'(s == 0 ? bit_timing_control_1 : s == 1 ?
                bit_timing_control_2 : bit_timing_control_3), 16'(c1));
        end
        $display("test config done");
        for (int k = 0; k < 6; k++) begin
            c1 = {2'(rnd()), 4'h0, 2'(rnd())};
            c2 = {1'(k), 1'b0, 6'(rnd())};
            c3 = 8'(rnd());
            cfg_write(can_pkg::SEL_CTRL1, c1, 1'b1);
            cfg_write(can_pkg::SEL_CTRL2, c2, 1'b1);
            cfg_write(can_pkg::SEL_CTRL3, c3, 1'b1);
            measure(n, off);
            measure(n, off);
            check("bit_len", 16'(n), 16'(bit_clk(c1, c2, c3, 1'b0)));
            check("sp_in_window", 16'(off <= bit_clk(c1, c2, c3, 1'b1)
                && off >= bit_clk(c1, c2, c3, 1'b1) - c1[5:0] - 1), 16'h0001);
        end
        $display("test timing done");
        for (int k = 0; k < 4; k++) begin
            cfg_write(can_pkg::SEL_CTRL1, 8'h07, 1'b1);
            cfg_write(can_pkg::SEL_CTRL2, {1'b0, 1'(k / 2), 6'h08}, 1'b1);
            measure(n, off);
            push(can_pkg::FLD_ACK, 1'b0, 1'b1, 1);
            wait_on(0);
            peer_level = 1'b0;
            repeat (off - 5 - (k % 2 == 1 ? 13 : 6)) @(negedge clk_sys);
            peer_level = 1'b1;
            repeat (k % 2 == 1 ? 16 : 9) @(negedge clk_sys);
            peer_level = 1'b0;
            wait_on(2);
            peer_level = 1'b1;
            check("rx_bit", 16'(rx_bit), 16'(maj_exp(k / 2, k % 2)));
            check("rx_field", 16'(rx_field), 16'(can_pkg::FLD_ACK));
        end
        $display("test sampling done");
        wait_on(0);
        push(can_pkg::FLD_ACK, 1'b0, 1'b1, FIFO_DEPTH + 1);
        n = 0;
        repeat (2500) begin
            @(negedge clk_sys);
            if (desc_ready === 1'b1) n++;
        end
        check("fifo_pops", 16'(n), 16'(FIFO_DEPTH));
        $display("test fifo done");
        cfg_write(can_pkg::SEL_CTRL1, 8'h01, 1'b1);
        cfg_write(can_pkg::SEL_CTRL2, 8'h00, 1'b1);
        run_case(can_pkg::FLD_ACK, 1'b1, 1'b1, 1'b1, 1, 5'h08);
        run_case(can_pkg::FLD_ACK, 1'b1, 1'b1, 1'b0, 1, 5'h00);
        run_case(can_pkg::FLD_DATA, 1'b1, 1'b1, 1'b0, 1, 5'h02);
        run_case(can_pkg::FLD_DATA, 1'b1, 1'b0, 1'b0, 3, 5'h00);
        run_case(can_pkg::FLD_ARB, 1'b1, 1'b1, 1'b0, 1, 5'h00);
        run_case(can_pkg::FLD_DATA, 1'b0, 1'b1, 1'b0, 6, 5'h01);
        for (int k = 0; k < 4; k++) begin
            run_case(form_f[k], 1'b0, 1'b1, 1'b0, 1, 5'h04);
        end
        $display("test errors done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
